/* File: rtl/srpd_pkg.sv */
/*
  srpd_pkg: address map, group codes and apb register map for the
  system region decoder. assumes a 32-bit byte address space.
*/
package srpd_pkg;
    localparam logic [31:0] SYS_BASE      = 32'he000_0000;
    localparam logic [31:0] PRIV_LAST     = 32'he00f_ffff;
    localparam logic [31:0] VEND_RSV_LO   = 32'he010_0000;
    localparam logic [31:0] VEND_RSV_HI   = 32'hefff_ffff;
    localparam logic [31:0] VEND_REC_BASE = 32'hf000_0000;
    localparam logic [31:0] SCS_BASE      = 32'he000_e000;
    localparam logic [31:0] SCS_LAST      = 32'he000_efff;
    localparam logic [11:0] CTL_LO        = 12'h000;
    localparam logic [11:0] CTL_HI        = 12'h00f;
    localparam logic [11:0] TICK_LO       = 12'h010;
    localparam logic [11:0] TICK_HI       = 12'h0ff;
    localparam logic [11:0] INTC_LO       = 12'h100;
    localparam logic [11:0] INTC_HI       = 12'hcff;
    localparam logic [11:0] SCB_LO        = 12'hd00;
    localparam logic [11:0] SCB_HI        = 12'hd8f;
    localparam logic [11:0] MPU_LO        = 12'hd90;
    localparam logic [11:0] MPU_HI        = 12'hdef;
    localparam logic [11:0] DBG_LO        = 12'hdf0;
    localparam logic [11:0] DBG_HI        = 12'heff;
    localparam logic [11:0] IMP_LO        = 12'hf90;
    localparam logic [11:0] IMP_HI        = 12'hfcf;
    localparam logic [1:0]  SIZE_WORD     = 2'h2;

    // apb register offsets
    localparam logic [11:0] REG_CFG       = 12'h000;
    localparam logic [11:0] REG_STATUS    = 12'h004;
    localparam logic [11:0] REG_FAULTADDR = 12'h008;
    localparam logic [11:0] REG_EVENTS    = 12'h00c;
    // cfg field positions and reset
    localparam int CFG_TICK   = 0;
    localparam int CFG_DBG    = 1;
    localparam int CFG_MPUEN  = 2;
    localparam int CFG_PRIVDF = 3;
    localparam int CFG_MPUIMP = 4;
    localparam logic [4:0] CFG_RESET = 5'h00;
    // event (clear-on-read) bit positions
    localparam int EV_PRIV  = 0;
    localparam int EV_ALIGN = 1;
    localparam int EV_XN    = 2;
    localparam int EV_RSV   = 3;

    typedef enum logic [3:0] {
        SRPD_NONE, SRPD_CTL, SRPD_TICK, SRPD_INTC, SRPD_MPU, SRPD_DBG,
        SRPD_IMP, SRPD_SCS_RSV, SRPD_PRIV_OTHER, SRPD_VENDOR, SRPD_FAULT
    } srpd_tgt_t;
endpackage

/* File: rtl/srpd_decoder.sv */
/*
  srpd_decoder: decodes one core request at a time into the system region,
  checks access rules, and answers with a registered target select, fault
  flag and byte-lane-fixed data. a small apb slave holds configuration and
  sticky fault and reserved-access events. assumes the core holds req for one cycle per access
  and the responder read data is valid in the cycle that tgt_sel is nonzero.
*/
`timescale 1ns/10ps
`default_nettype none
module srpd_decoder
    import srpd_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // core request
    input  wire logic        req_valid,
    input  wire logic [31:0] req_addr,
    input  wire logic        req_write,
    input  wire logic        req_priv,
    input  wire logic        req_fetch,
    input  wire logic [1:0]  req_size,
    input  wire logic        req_big_endian,
    input  wire logic [31:0] req_wdata,
    // core answer
    output logic             rsp_valid,
    output logic             rsp_fault,
    output logic [31:0]      rsp_rdata,
    // responder side
    output logic [3:0]       tgt_sel,
    output logic             tgt_write,
    output logic [11:0]      tgt_offset,
    output logic [31:0]      tgt_wdata,
    output logic             tgt_map_bypass,
    output logic             hard_fault,
    input  wire logic [31:0] tgt_rdata,
    // protection unit result for non-default map
    input  wire logic        mpu_hit,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata
);

    typedef struct packed {
        logic        rsp_valid;
        logic        rsp_fault;
        logic [31:0] rsp_rdata;
        logic        pend;
        logic        pend_big;
        logic        pend_rsv;
        logic [3:0]  tgt_sel;
        logic        tgt_write;
        logic [11:0] tgt_offset;
        logic [31:0] tgt_wdata;
        logic        bypass;
        logic        hard_fault;
        logic [4:0]  cfg;
        logic [3:0]  events;
        logic [31:0] fault_addr;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } srpd_state_t;

    srpd_state_t st_r, st_nxt;

    function automatic logic in_rng(input logic [11:0] a, input logic [11:0] lo,
                                    input logic [11:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [31:0] swap32(input logic [31:0] d);
        swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction

    srpd_tgt_t   tgt;
    logic        in_sys, in_priv, in_scs, fault_priv, fault_align, fault_xn;
    logic        is_rsv, bypass;
    logic [11:0] off;
    logic        rd_events;
    logic [3:0]  ev_set;

    always_comb begin
        st_nxt      = st_r;
        in_sys      = req_addr >= SYS_BASE;
        in_priv     = in_sys && (req_addr <= PRIV_LAST);
        in_scs      = (req_addr >= SCS_BASE) && (req_addr <= SCS_LAST);
        off         = req_addr[11:0];
        fault_priv  = in_priv && !req_priv;
        fault_align = in_priv && ((req_size != SIZE_WORD) || (req_addr[1:0] != 2'h0));
        fault_xn    = in_sys && req_fetch;
        // default map when unit absent, off, or privileged background
        bypass      = !st_r.cfg[CFG_MPUIMP] || !st_r.cfg[CFG_MPUEN]
                      || (req_priv && st_r.cfg[CFG_PRIVDF] && !mpu_hit);
        is_rsv      = 1'b0;
        tgt         = SRPD_NONE;
        if (!in_sys) begin
            tgt = SRPD_NONE;
        end else if (fault_xn || fault_priv || fault_align) begin
            tgt = SRPD_FAULT;
        end else if (!in_priv) begin
            // reserved span still routed to vendor fabric
            tgt = SRPD_VENDOR;
        end else if (!in_scs) begin
            tgt = SRPD_PRIV_OTHER;
        end else if (in_rng(off, CTL_LO, CTL_HI) || in_rng(off, SCB_LO, SCB_HI)) begin
            tgt = SRPD_CTL;
        end else if (in_rng(off, IMP_LO, IMP_HI)) begin
            tgt = SRPD_IMP;
        // tick, mpu and dbg groups gated by feature bits; intc is not gated
        end else if (in_rng(off, TICK_LO, TICK_HI) && st_r.cfg[CFG_TICK]) begin
            tgt = SRPD_TICK;
        end else if (in_rng(off, INTC_LO, INTC_HI)) begin
            tgt = SRPD_INTC;
        end else if (in_rng(off, MPU_LO, MPU_HI) && st_r.cfg[CFG_MPUIMP]) begin
            tgt = SRPD_MPU;
        end else if (in_rng(off, DBG_LO, DBG_HI) && st_r.cfg[CFG_DBG]) begin
            tgt = SRPD_DBG;
        end else begin
            tgt    = SRPD_SCS_RSV;
            is_rsv = 1'b1;
        end

        // one access in flight, issued in order, never merged
        st_nxt.tgt_sel    = 4'(SRPD_NONE);
        st_nxt.tgt_write  = 1'b0;
        st_nxt.hard_fault = 1'b0;
        st_nxt.rsp_valid  = 1'b0;
        st_nxt.rsp_fault  = 1'b0;
        st_nxt.rsp_rdata  = 32'h0;
        st_nxt.pend       = 1'b0;
        ev_set            = 4'h0;
        if (st_r.pend) begin
            st_nxt.rsp_valid = 1'b1;
            st_nxt.rsp_rdata = st_r.pend_rsv ? 32'h0
                             : (st_r.pend_big ? swap32(tgt_rdata) : tgt_rdata);
        end else if (req_valid && in_sys) begin
            if (tgt == SRPD_FAULT) begin
                st_nxt.rsp_valid  = 1'b1;
                st_nxt.rsp_fault  = 1'b1;
                st_nxt.hard_fault = 1'b1;
                st_nxt.fault_addr = req_addr;
                ev_set[EV_PRIV]   = fault_priv;
                ev_set[EV_ALIGN]  = fault_align;
                ev_set[EV_XN]     = fault_xn;
            end else begin
                st_nxt.pend       = 1'b1;
                st_nxt.pend_rsv   = is_rsv;
                st_nxt.pend_big   = in_priv && req_big_endian;
                st_nxt.tgt_sel    = is_rsv ? 4'(SRPD_NONE) : 4'(tgt);
                st_nxt.tgt_write  = req_write && !is_rsv;
                st_nxt.tgt_offset = off;
                st_nxt.tgt_wdata  = (in_priv && req_big_endian) ? swap32(req_wdata) : req_wdata;
                st_nxt.bypass     = bypass;
                ev_set[EV_RSV]    = is_rsv;
            end
        end

        // apb slave, one wait-free access phase
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;
        rd_events      = 1'b0;
        // writes and clear-on-read act only at the completing edge of the access phase
        if (psel && penable && st_r.pready) begin
            if (pwrite && paddr == REG_CFG) begin
                st_nxt.cfg = pwdata[4:0];
            end
            rd_events = !pwrite && (paddr == REG_EVENTS);
        end
        if (psel && !penable) begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = 32'h0;
            if (paddr == REG_CFG) begin
                st_nxt.prdata = {27'h0, st_r.cfg};
            end else if (paddr == REG_STATUS) begin
                st_nxt.prdata = {27'h0, st_r.bypass, st_r.pend, st_r.tgt_sel[2:0]};
            end else if (paddr == REG_FAULTADDR) begin
                st_nxt.prdata = st_r.fault_addr;
            end else if (paddr == REG_EVENTS) begin
                st_nxt.prdata = {28'h0, st_r.events};
            end else begin
                st_nxt.pslverr = 1'b1;
            end
        end
        // read clears only bits it returned as one; new set survives
        // mask is the value the reader was shown, so a later set is kept
        st_nxt.events = (rd_events ? (st_r.events & ~st_r.prdata[3:0]) : st_r.events) | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r     <= '0;
            st_r.cfg <= CFG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rsp_valid      = st_r.rsp_valid;
    assign rsp_fault      = st_r.rsp_fault;
    assign rsp_rdata      = st_r.rsp_rdata;
    assign tgt_sel        = st_r.tgt_sel;
    assign tgt_write      = st_r.tgt_write;
    assign tgt_offset     = st_r.tgt_offset;
    assign tgt_wdata      = st_r.tgt_wdata;
    assign tgt_map_bypass = st_r.bypass;
    assign hard_fault     = st_r.hard_fault;
    assign pready         = st_r.pready;
    assign pslverr        = st_r.pslverr;
    assign prdata         = st_r.prdata;

    // assertions
    AST_PRIV_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
        req_valid && !st_r.pend && fault_priv |=> hard_fault && tgt_sel == 4'(SRPD_NONE))
        else $error("unprivileged private access not faulted");
    AST_ALIGN: assert property (@(posedge pclk) disable iff (!presetn)
        req_valid && !st_r.pend && in_priv && req_size != SIZE_WORD |=> rsp_fault)
        else $error("sub-word private access not faulted");
    AST_XN: assert property (@(posedge pclk) disable iff (!presetn)
        req_valid && !st_r.pend && in_sys && req_fetch |=> rsp_valid && rsp_fault)
        else $error("fetch from execute-never region allowed");
    AST_VENDOR: assert property (@(posedge pclk) disable iff (!presetn)
        req_valid && !st_r.pend && req_addr >= VEND_RSV_LO && !req_fetch
        |=> tgt_sel == 4'(SRPD_VENDOR) ##1 rsp_valid && !rsp_fault)
        else $error("vendor region misrouted");
    AST_RSV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        req_valid && !st_r.pend && tgt == SRPD_SCS_RSV
        |=> !tgt_write ##1 rsp_valid && rsp_rdata == 32'h0 && !rsp_fault)
        else $error("reserved space not read as zero");
    AST_TICK: assert property (@(posedge pclk) disable iff (!presetn)
        req_valid && !st_r.pend && tgt == SRPD_TICK |=> tgt_offset >= TICK_LO && tgt_offset <= TICK_HI)
        else $error("tick timer range misrouted");
    AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        tgt_sel != 4'(SRPD_NONE) |=> tgt_sel == 4'(SRPD_NONE))
        else $error("back-to-back forwarded accesses");
    AST_COR: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && paddr == REG_EVENTS
        |=> st_r.events == (($past(st_r.events) & ~$past(prdata[3:0])) | $past(ev_set)))
        else $error("coincident set lost on clear-on-read");
    AST_CFG: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && paddr == REG_CFG |=> st_r.cfg == $past(pwdata[4:0]))
        else $error("feature bits not written");
    AST_MAP: assert property (@(posedge pclk) disable iff (!presetn)
        !st_r.cfg[CFG_MPUIMP] && req_valid && !st_r.pend && in_sys && tgt != SRPD_FAULT
        |=> tgt_map_bypass)
        else $error("default map not used without protection unit");

    COV_PRIV_FAULT: cover property (@(posedge pclk) disable iff (!presetn) hard_fault);
    COV_CTL_READ:   cover property (@(posedge pclk) disable iff (!presetn)
        tgt_sel == 4'(SRPD_CTL) ##1 rsp_valid);
    COV_RSV:        cover property (@(posedge pclk) disable iff (!presetn)
        st_r.events[EV_RSV]);
    COV_APB:        cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule
`default_nettype wire

/* File: tb/srpd_resp_model.sv */
/*
  srpd_resp_model: behavioural register-group responder behind the decoder.
  assumes read data is wanted in the cycle that tgt_sel is nonzero.
*/
`timescale 1ns/10ps
`default_nettype none
module srpd_resp_model
    import srpd_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // select from the decoder
    input  wire logic [3:0]  tgt_sel,
    input  wire logic [11:0] tgt_offset,
    // read data back
    output logic [31:0]      tgt_rdata
);
    logic [31:0] junk_r;

    // idle data changes every cycle so a stale sample never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            junk_r <= 32'h0;
        end else begin
            junk_r <= ~junk_r ^ 32'h1;
        end
    end

    assign tgt_rdata = (tgt_sel != 4'h0) ? {20'hc0ffe, tgt_offset} : junk_r;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
  tb: self-checking bench for srpd_decoder with a responder model.
  assumes a 20 MHz pclk and the one-access-in-flight core contract.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
    import srpd_pkg::*;
    logic        pclk, presetn, req_valid, req_write, req_priv, req_fetch;
    logic        req_big_endian, mpu_hit, psel, penable, pwrite;
    logic [1:0]  req_size;
    logic [11:0] paddr;
    logic [31:0] req_addr, req_wdata, pwdata, tgt_rdata, seed_val;
    logic        rsp_valid, rsp_fault, tgt_write, tgt_map_bypass, hard_fault, pready, pslverr;
    logic [31:0] rsp_rdata, tgt_wdata, prdata, rd;
    logic [3:0]  tgt_sel;
    logic [11:0] tgt_offset;
    logic [4:0]  cfg;
    logic        err;
    int          mismatches, compares;
    logic [31:0] corner[16] = '{32'hdffffffc, 32'he00ffffc, 32'he0100000, 32'he000e00c,
        32'he000e010, 32'he000ecfc, 32'he000ed8c, 32'he000ed90, 32'he000edec, 32'he000edf0,
        32'he000eefc, 32'he000ef8c, 32'he000ef90, 32'he000efcc, 32'he000efd0, 32'heffffffc};
    logic [31:0] ev_addr[4] = '{32'he000ed00, 32'he000ed04, 32'hf0000000, 32'he000ef00};

    srpd_decoder dut (.pclk(pclk), .presetn(presetn), .req_valid(req_valid),
        .req_addr(req_addr), .req_write(req_write), .req_priv(req_priv),
        .req_fetch(req_fetch), .req_size(req_size), .req_big_endian(req_big_endian),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_fault(rsp_fault),
        .rsp_rdata(rsp_rdata), .tgt_sel(tgt_sel), .tgt_write(tgt_write),
        .tgt_offset(tgt_offset), .tgt_wdata(tgt_wdata), .tgt_map_bypass(tgt_map_bypass),
        .hard_fault(hard_fault), .tgt_rdata(tgt_rdata), .mpu_hit(mpu_hit), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata));
    srpd_resp_model resp (.pclk(pclk), .presetn(presetn), .tgt_sel(tgt_sel),
        .tgt_offset(tgt_offset), .tgt_rdata(tgt_rdata));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic print_verdict();
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    function automatic srpd_tgt_t predict(input logic [31:0] a, input logic pr, f,
                                          input logic [1:0] sz);
        logic [11:0] o;
        o = a[11:0];
        if (a < SYS_BASE) return SRPD_NONE;
        if (f) return SRPD_FAULT;
        if (a > PRIV_LAST) return SRPD_VENDOR;
        if (!pr || sz !== SIZE_WORD) return SRPD_FAULT;
        if (a < SCS_BASE || a > SCS_LAST) return SRPD_PRIV_OTHER;
        if (o <= CTL_HI) return SRPD_CTL;
        if (o <= TICK_HI) return cfg[CFG_TICK] ? SRPD_TICK : SRPD_SCS_RSV;
        if (o <= INTC_HI) return SRPD_INTC;
        if (o <= SCB_HI) return SRPD_CTL;
        if (o <= MPU_HI) return cfg[CFG_MPUIMP] ? SRPD_MPU : SRPD_SCS_RSV;
        if (o <= DBG_HI) return cfg[CFG_DBG] ? SRPD_DBG : SRPD_SCS_RSV;
        if (o >= IMP_LO && o <= IMP_HI) return SRPD_IMP;
        return SRPD_SCS_RSV;
    endfunction

    function automatic logic [31:0] swap(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // apb master: zero-wait slave is not assumed, ready is polled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task automatic set_cfg(input logic [4:0] v);
        logic [31:0] q;
        logic        e;
        apb(1'b1, REG_CFG, {27'h0, v}, q, e); // whole word written
        cfg = v;
        apb(1'b0, REG_CFG, 32'h0, q, e);
        chk(q[4:0] === v && e === 1'b0, "cfg readback");
    endtask

    task automatic access(input logic [31:0] a, input logic pr, f, w, be, h,
                          input logic [1:0] sz);
        srpd_tgt_t   e;
        logic [31:0] wd, q, gwd;
        logic [11:0] goff;
        logic [3:0]  gsel;
        logic        gw, gbyp, grsp, gflt, ghf;
        int          nsel;
        e = predict(a, pr, f, sz);
        wd = $urandom;
        {gsel, goff, gwd, gw, gbyp, grsp, gflt, ghf, q} = '0;
        nsel = 0;
        @(posedge pclk);
        {req_valid, req_addr, req_write, req_priv, req_fetch, req_size, req_big_endian,
            req_wdata, mpu_hit} <= {1'b1, a, w, pr, f, sz, be, wd, h};
        @(posedge pclk);
        req_valid <= 1'b0;
        repeat (4) begin
            #1;
            if (tgt_sel !== 4'h0) begin
                nsel++;
                {gsel, goff, gwd, gw, gbyp} = {tgt_sel, tgt_offset, tgt_wdata, tgt_write,
                    tgt_map_bypass};
            end
            if (hard_fault === 1'b1) ghf = 1'b1;
            if (rsp_valid === 1'b1) {grsp, gflt, q} = {1'b1, rsp_fault, rsp_rdata};
            @(posedge pclk);
        end
        if (e == SRPD_NONE) begin
            chk(grsp === 1'b0 && ghf === 1'b0 && nsel == 0, "answer off region");
        end else if (e == SRPD_FAULT) begin
            chk(grsp && gflt === 1'b1 && ghf === 1'b1, "no fault");
            chk(nsel == 0, "faulted access forwarded");
        end else if (e == SRPD_SCS_RSV) begin
            chk(grsp && !gflt && !ghf && q === 32'h0 && nsel == 0, "reserved");
        end else begin
            chk(nsel == 1 && gsel === 4'(e) && goff === a[11:0] && gw === w, "route");
            chk(grsp && gflt === 1'b0 && gbyp === (!(cfg[CFG_MPUEN] && cfg[CFG_MPUIMP])
                || (pr && cfg[CFG_PRIVDF] && !h)),
                "answer or map");
            if (w) chk(gwd === ((be && a <= PRIV_LAST) ? swap(wd) : wd), "lanes");
            else chk(q === ((be && a <= PRIV_LAST) ? swap({20'hc0ffe, a[11:0]})
                : {20'hc0ffe, a[11:0]}), "read data");
        end
    endtask

    initial begin
        {req_valid, req_write, req_priv, req_fetch, req_big_endian, mpu_hit} = '0;
        {psel, penable, pwrite, paddr, pwdata, req_addr, req_wdata, req_size} = '0;
        {mismatches, compares, cfg} = '0;
        presetn = 1'b0;
        seed_val = $urandom(32'h42d7d958);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_CFG, 32'h0, rd, err);
        chk(rd[4:0] === CFG_RESET && err === 1'b0, "cfg reset");
        apb(1'b1, 12'h010, 32'hffffffff, rd, err);
        chk(err === 1'b1, "unmapped write");
        apb(1'b0, 12'h010, 32'h0, rd, err);
        chk(err === 1'b1 && rd === 32'h0, "unmapped read");
        set_cfg(5'h1f);
        set_cfg(5'h13);
        foreach (corner[i]) access(corner[i], 1'b1, 1'b0, 1'($urandom), 1'($urandom), 1'b0, SIZE_WORD);
        // two configurations: features present, then all absent
        for (int c = 0; c < 2; c++) begin
            set_cfg(c == 0 ? 5'h13 : 5'h00);
            repeat (100) begin
                int r;
                r = $urandom % 4;
                access(r == 0 ? SCS_BASE | ($urandom & 32'h0ffc) :
                       r == 1 ? SYS_BASE | ($urandom & 32'h000ffffc) :
                       r == 2 ? SYS_BASE | ($urandom & 32'h1ffffffc) : $urandom & 32'hfffffffc,
                       ($urandom % 8) != 0, ($urandom % 8) == 0, 1'($urandom), 1'($urandom),
                       1'($urandom), ($urandom % 4) == 0 ? 2'($urandom % 2) : SIZE_WORD);
            end
        end
        set_cfg(5'h1c);
        access(VEND_REC_BASE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, SIZE_WORD);
        access(VEND_REC_BASE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, SIZE_WORD);
        set_cfg(5'h13);
        apb(1'b0, REG_EVENTS, 32'h0, rd, err);
        // event index k follows the event bit order: priv, align, fetch, reserved
        for (int k = 0; k < 4; k++) begin
            access(ev_addr[k], k != 0, k == 2, 1'b0, 1'b0, 1'b0, k == 1 ? 2'h0 : SIZE_WORD);
            apb(1'b0, REG_EVENTS, 32'h0, rd, err);
            chk(rd[3:0] === 4'(1 << k), "event set");
            apb(1'b0, REG_FAULTADDR, 32'h0, rd, err);
            if (k != 3) chk(rd === ev_addr[k], "fault address");
            apb(1'b0, REG_EVENTS, 32'h0, rd, err);
            chk(rd[3:0] === 4'h0, "event not cleared");
        end
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
